// file: hdl/isp_flash_pkg.sv
// constants, encodings and carriers for the isp flash sequencer
// assumes a 32-bit apb register bus and one core clock
package isp_flash_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_KEY  = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h04;
	localparam logic [7:0] OFS_AH   = 8'h08;
	localparam logic [7:0] OFS_AL   = 8'h0c;
	localparam logic [7:0] OFS_DATA = 8'h10;
	localparam logic [7:0] OFS_GO   = 8'h14;
	localparam logic [7:0] OFS_STAT = 8'h18;
	localparam logic [7:0] OFS_SEC  = 8'h1c;
	localparam logic [7:0] OFS_MID  = 8'h20;
	localparam logic [7:0] OFS_DID  = 8'h24;

	// unlock key bytes
	localparam logic [7:0] KEY_FIRST  = 8'h87;
	localparam logic [7:0] KEY_SECOND = 8'h59;

	// isp control field positions
	localparam int         BANK_BIT  = 6;
	localparam int         OE_BIT    = 5;
	localparam int         CE_BIT    = 4;
	localparam logic [7:0] CTRL_MASK = 8'h7f;
	localparam logic [7:0] CTRL_RST  = 8'h00;

	// operation codes
	localparam logic [3:0] CODE_READ  = 4'h0;
	localparam logic [3:0] CODE_PROG  = 4'h1;
	localparam logic [3:0] CODE_ERASE = 4'h2;

	// security and option bit positions
	localparam int         SEC_LOCK   = 0;
	localparam int         SEC_MOVC   = 1;
	localparam int         SEC_CYCLE  = 5;
	localparam int         SEC_XTAL   = 7;
	localparam logic [7:0] SEC_ERASED = 8'hff;

	// status bit positions
	localparam int STAT_OPEN   = 0;
	localparam int STAT_BUSY   = 1;
	localparam int STAT_PMODE  = 2;
	localparam int STAT_LOCKED = 3;
	localparam int STAT_REFUSE = 4;

	typedef enum logic [1:0] {
		OP_READ  = 2'b00,
		OP_PROG  = 2'b01,
		OP_ERASE = 2'b10
	} op_e;

	typedef enum logic [1:0] {
		KEY_SHUT = 2'b00,
		KEY_HALF = 2'b01,
		KEY_OPEN = 2'b11
	} key_e;

	typedef enum logic {
		SEQ_IDLE = 1'b0,
		SEQ_BUSY = 1'b1
	} seq_e;

	typedef struct packed {
		logic        req;
		op_e         op;
		logic        bank;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} flash_cmd_s;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		key_e        key;
		logic [7:0]  ctrl;
		logic [7:0]  ah;
		logic [7:0]  al;
		logic [7:0]  data;
		seq_e        seq;
		flash_cmd_s  cmd;
		logic        refused;
		logic [7:0]  sec;
		logic        cap;
		logic        movc_ok;
		logic        cyc6;
		logic        xtal40;
	} isp_state_s;

	typedef struct packed {
		logic meta;
		logic sync;
	} sync_state_s;

endpackage

// file: hdl/level_sync.sv
// two flip-flop synchroniser for one level
// assumes the input may change at any time relative to mclk_i
`timescale 1ns/1ps
module level_sync (
	input  wire logic mclk_i,
	input  wire logic resetn_i,
	input  wire logic async_i,
	output logic      sync_o
);
	isp_flash_pkg::sync_state_s s_r;
	isp_flash_pkg::sync_state_s s_nxt;

	always_comb begin
		s_nxt      = s_r;
		s_nxt.meta = async_i;
		s_nxt.sync = s_r.meta;
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sync_o = s_r.sync;
endmodule

// file: hdl/isp_flash_seq.sv
// isp flash command sequencer with security and option bits
// assumes an apb master on mclk_i and a flash array answering with done
//
// Behaviour
// - code 0010, oe 1, ce 0 erases the selected bank; address ignored.
// - code 0001, oe 1, ce 0 programs data byte at address.
// - code 0000, oe 0, ce 0 reads byte at address into data.
// - bank select 0 is application bank, 1 is loader bank.
// - security and id registers unreadable in programming mode.
// - a security bit at 0 returns to 1 only by full erase.
// - lock bit 0 at 0 refuses flash and special register access.
// - restriction bit 1 at 0 keeps external code-table reads off internal flash.
// - code-table reads from internal memory may always reach both.
// - restriction bit 1 at 1 places no limit on code-table reads.
// - cycle bit 5 at 1 gives 12-clock cycle, at 0 six-clock.
// - crystal bit 7 at 0 is low-emission 24 MHz, 1 is 40 MHz.
// - manufacturer and part ids are fixed and not writable.
// - target address is a high byte and a low byte register.
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
module isp_flash_seq #(
	// arbitrary identity values
	parameter logic [7:0] MFR_ID = 8'h5a,
	parameter logic [7:0] DEV_ID = 8'h3c
) (
	input  wire logic                      mclk_i,
	input  wire logic                      resetn_i,
	input  wire logic [7:0]                paddr_i,
	input  wire logic                      psel_i,
	input  wire logic                      penable_i,
	input  wire logic                      pwrite_i,
	input  wire logic [31:0]               pwdata_i,
	output logic [31:0]                    prdata_o,
	output logic                           pready_o,
	output logic                           pslverr_o,
	input  wire logic                      prog_mode_i,
	input  wire logic [7:0]                sec_bits_i,
	input  wire logic                      full_erase_i,
	input  wire logic                      flash_done_i,
	input  wire logic [7:0]                flash_rdata_i,
	output isp_flash_pkg::flash_cmd_s      flash_cmd_o,
	input  wire logic                      movc_from_int_i,
	input  wire logic                      movc_to_int_i,
	output logic                           movc_int_ok_o,
	output logic                           cycle_6t_o,
	output logic                           xtal_40m_o
);
	isp_flash_pkg::isp_state_s s_r;
	isp_flash_pkg::isp_state_s s_nxt;
	logic                      pmode;
	logic                      setup;
	logic                      wr;
	logic                      mapped;
	logic                      locked;
	logic                      hidden;
	logic                      go_ok;
	isp_flash_pkg::op_e        go_op;

	level_sync level_sync_inst (
		.mclk_i   (mclk_i),
		.resetn_i (resetn_i),
		.async_i  (prog_mode_i),
		.sync_o   (pmode)
	);

	assign setup  = psel_i & ~penable_i;
	assign wr     = psel_i & penable_i & s_r.pready & pwrite_i;
	assign locked = ~s_r.sec[isp_flash_pkg::SEC_LOCK];
	assign hidden = pmode | locked;

	always_comb begin
		unique case (paddr_i)
			isp_flash_pkg::OFS_KEY,  isp_flash_pkg::OFS_CTRL,
			isp_flash_pkg::OFS_AH,   isp_flash_pkg::OFS_AL,
			isp_flash_pkg::OFS_DATA, isp_flash_pkg::OFS_GO,
			isp_flash_pkg::OFS_STAT, isp_flash_pkg::OFS_SEC,
			isp_flash_pkg::OFS_MID,  isp_flash_pkg::OFS_DID: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// operation decode from the control fields
	always_comb begin
		go_ok = 1'b0;
		go_op = isp_flash_pkg::OP_READ;
		if (!s_r.ctrl[isp_flash_pkg::CE_BIT]) begin
			if (s_r.ctrl[isp_flash_pkg::OE_BIT]) begin
				if (s_r.ctrl[3:0] == isp_flash_pkg::CODE_ERASE) begin
					go_ok = 1'b1;
					go_op = isp_flash_pkg::OP_ERASE;
				end else if (s_r.ctrl[3:0] == isp_flash_pkg::CODE_PROG) begin
					go_ok = 1'b1;
					go_op = isp_flash_pkg::OP_PROG;
				end
			end else if (s_r.ctrl[3:0] == isp_flash_pkg::CODE_READ) begin
				go_ok = 1'b1;
				go_op = isp_flash_pkg::OP_READ;
			end
		end
	end

	always_comb begin
		s_nxt         = s_r;
		s_nxt.pready  = setup;
		s_nxt.movc_ok = movc_from_int_i | ~movc_to_int_i |
			s_r.sec[isp_flash_pkg::SEC_MOVC];
		s_nxt.cyc6    = ~s_r.sec[isp_flash_pkg::SEC_CYCLE];
		s_nxt.xtal40  = s_r.sec[isp_flash_pkg::SEC_XTAL];

		// security latch: loaded once after reset, only erase lifts bits
		if (!s_r.cap) begin
			s_nxt.sec = sec_bits_i;
			s_nxt.cap = 1'b1;
		end else if (full_erase_i) begin
			s_nxt.sec = isp_flash_pkg::SEC_ERASED;
		end

		// read data and error answer prepared in the setup cycle
		if (setup) begin
			s_nxt.pslverr = ~mapped;
			s_nxt.prdata  = '0;
			unique case (paddr_i)
				isp_flash_pkg::OFS_CTRL: s_nxt.prdata[7:0] = s_r.ctrl;
				isp_flash_pkg::OFS_AH:   s_nxt.prdata[7:0] = s_r.ah;
				isp_flash_pkg::OFS_AL:   s_nxt.prdata[7:0] = s_r.al;
				isp_flash_pkg::OFS_DATA: s_nxt.prdata[7:0] = s_r.data;
				isp_flash_pkg::OFS_STAT: begin
					s_nxt.prdata[isp_flash_pkg::STAT_OPEN] =
						(s_r.key == isp_flash_pkg::KEY_OPEN);
					s_nxt.prdata[isp_flash_pkg::STAT_BUSY] =
						(s_r.seq == isp_flash_pkg::SEQ_BUSY);
					s_nxt.prdata[isp_flash_pkg::STAT_PMODE]  = pmode;
					s_nxt.prdata[isp_flash_pkg::STAT_LOCKED] = locked;
					s_nxt.prdata[isp_flash_pkg::STAT_REFUSE] = s_r.refused;
				end
				isp_flash_pkg::OFS_SEC: begin
					if (!hidden) begin
						s_nxt.prdata[7:0] = s_r.sec;
					end
				end
				isp_flash_pkg::OFS_MID: begin
					if (!hidden) begin
						s_nxt.prdata[7:0] = MFR_ID;
					end
				end
				isp_flash_pkg::OFS_DID: begin
					if (!hidden) begin
						s_nxt.prdata[7:0] = DEV_ID;
					end
				end
				default: s_nxt.prdata = '0;
			endcase
		end

		// flash operation in flight
		if (s_r.seq == isp_flash_pkg::SEQ_BUSY && flash_done_i) begin
			s_nxt.cmd.req = 1'b0;
			s_nxt.seq     = isp_flash_pkg::SEQ_IDLE;
			if (s_r.cmd.op == isp_flash_pkg::OP_READ) begin
				s_nxt.data = flash_rdata_i;
			end
		end

		// register writes at the completing access edge
		if (wr) begin
			unique case (paddr_i)
				isp_flash_pkg::OFS_KEY: begin
					if (pwdata_i[7:0] == isp_flash_pkg::KEY_FIRST) begin
						s_nxt.key = isp_flash_pkg::KEY_HALF;
					end else if (pwdata_i[7:0] == isp_flash_pkg::KEY_SECOND
						&& s_r.key == isp_flash_pkg::KEY_HALF) begin
						s_nxt.key = isp_flash_pkg::KEY_OPEN;
					end else begin
						s_nxt.key = isp_flash_pkg::KEY_SHUT;
					end
				end
				isp_flash_pkg::OFS_CTRL: begin
					if (s_r.key == isp_flash_pkg::KEY_OPEN &&
						s_r.seq == isp_flash_pkg::SEQ_IDLE) begin
						s_nxt.ctrl = pwdata_i[7:0] & isp_flash_pkg::CTRL_MASK;
					end
				end
				isp_flash_pkg::OFS_AH: begin
					if (s_r.seq == isp_flash_pkg::SEQ_IDLE) begin
						s_nxt.ah = pwdata_i[7:0];
					end
				end
				isp_flash_pkg::OFS_AL: begin
					if (s_r.seq == isp_flash_pkg::SEQ_IDLE) begin
						s_nxt.al = pwdata_i[7:0];
					end
				end
				isp_flash_pkg::OFS_DATA: begin
					if (s_r.seq == isp_flash_pkg::SEQ_IDLE) begin
						s_nxt.data = pwdata_i[7:0];
					end
				end
				isp_flash_pkg::OFS_GO: begin
					if (s_r.seq == isp_flash_pkg::SEQ_IDLE) begin
						if (locked || !go_ok) begin
							s_nxt.refused = 1'b1;
						end else begin
							s_nxt.refused   = 1'b0;
							s_nxt.seq       = isp_flash_pkg::SEQ_BUSY;
							s_nxt.cmd.req   = 1'b1;
							s_nxt.cmd.op    = go_op;
							s_nxt.cmd.bank  =
								s_r.ctrl[isp_flash_pkg::BANK_BIT];
							s_nxt.cmd.addr  = {s_r.ah, s_r.al};
							s_nxt.cmd.wdata = s_r.data;
						end
					end
				end
				default: s_nxt.key = s_r.key;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			s_r        <= '0;
			s_r.ctrl   <= isp_flash_pkg::CTRL_RST;
			s_r.sec    <= isp_flash_pkg::SEC_ERASED;
			s_r.key    <= isp_flash_pkg::KEY_SHUT;
			s_r.seq    <= isp_flash_pkg::SEQ_IDLE;
			s_r.cyc6   <= 1'b0;
			s_r.xtal40 <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata_o      = s_r.prdata;
	assign pready_o      = s_r.pready;
	assign pslverr_o     = s_r.pslverr;
	assign flash_cmd_o   = s_r.cmd;
	assign movc_int_ok_o = s_r.movc_ok;
	assign cycle_6t_o    = s_r.cyc6;
	assign xtal_40m_o    = s_r.xtal40;

	logic go_wr;
	assign go_wr = wr && paddr_i == isp_flash_pkg::OFS_GO &&
		s_r.seq == isp_flash_pkg::SEQ_IDLE;

	property p_erase;
		@(posedge mclk_i) disable iff (!resetn_i)
		go_wr && !locked && s_r.ctrl[3:0] == isp_flash_pkg::CODE_ERASE &&
		s_r.ctrl[isp_flash_pkg::OE_BIT] && !s_r.ctrl[isp_flash_pkg::CE_BIT]
		|=> flash_cmd_o.req && flash_cmd_o.op == isp_flash_pkg::OP_ERASE;
	endproperty
	a_erase: assert property (p_erase)
		else $error("erase not issued");

	property p_prog;
		@(posedge mclk_i) disable iff (!resetn_i)
		go_wr && !locked && go_ok && go_op == isp_flash_pkg::OP_PROG
		|=> flash_cmd_o.addr == {$past(s_r.ah), $past(s_r.al)} &&
		flash_cmd_o.wdata == $past(s_r.data);
	endproperty
	a_prog: assert property (p_prog)
		else $error("program address or data wrong");

	property p_read;
		@(posedge mclk_i) disable iff (!resetn_i)
		s_r.seq == isp_flash_pkg::SEQ_BUSY && flash_done_i &&
		flash_cmd_o.op == isp_flash_pkg::OP_READ
		|=> s_r.data == $past(flash_rdata_i) && !flash_cmd_o.req;
	endproperty
	a_read: assert property (p_read)
		else $error("read byte not returned");

	property p_bank;
		@(posedge mclk_i) disable iff (!resetn_i)
		flash_cmd_o.req |->
		flash_cmd_o.bank == s_r.ctrl[isp_flash_pkg::BANK_BIT];
	endproperty
	a_bank: assert property (p_bank)
		else $error("bank differs from select bit");

	property p_hide;
		@(posedge mclk_i) disable iff (!resetn_i)
		setup && pmode && (paddr_i == isp_flash_pkg::OFS_SEC ||
		paddr_i == isp_flash_pkg::OFS_MID) |=> prdata_o == '0;
	endproperty
	a_hide: assert property (p_hide)
		else $error("special register visible in programming mode");

	property p_sticky;
		@(posedge mclk_i) disable iff (!resetn_i)
		s_r.cap && !full_erase_i |=> (s_r.sec & ~$past(s_r.sec)) == '0;
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("security bit returned to one without erase");

	property p_lock;
		@(posedge mclk_i) disable iff (!resetn_i)
		go_wr && locked |=> !flash_cmd_o.req && s_r.refused;
	endproperty
	a_lock: assert property (p_lock)
		else $error("flash access while locked");

	property p_movc;
		@(posedge mclk_i) disable iff (!resetn_i)
		s_r.cap && !full_erase_i ##1 1'b1 |-> movc_int_ok_o ==
		($past(movc_from_int_i) | ~$past(movc_to_int_i) |
		s_r.sec[isp_flash_pkg::SEC_MOVC]);
	endproperty
	a_movc: assert property (p_movc)
		else $error("code-table read gating wrong");

	property p_cycle;
		@(posedge mclk_i) disable iff (!resetn_i)
		s_r.cap |=> cycle_6t_o == !$past(s_r.sec[isp_flash_pkg::SEC_CYCLE])
		&& xtal_40m_o == $past(s_r.sec[isp_flash_pkg::SEC_XTAL]);
	endproperty
	a_cycle: assert property (p_cycle)
		else $error("option outputs do not follow security bits");

	property p_id;
		@(posedge mclk_i) disable iff (!resetn_i)
		setup && !hidden && paddr_i == isp_flash_pkg::OFS_DID
		|=> prdata_o[7:0] == DEV_ID;
	endproperty
	a_id: assert property (p_id)
		else $error("part id read wrong");

	property p_hold;
		@(posedge mclk_i) disable iff (!resetn_i)
		s_r.cap && !full_erase_i |=> $stable(s_r.sec);
	endproperty
	a_hold: assert property (p_hold)
		else $error("security latch changed");

	property p_locked_hide;
		@(posedge mclk_i) disable iff (!resetn_i)
		setup && locked && paddr_i == isp_flash_pkg::OFS_SEC
		|=> prdata_o == '0;
	endproperty
	a_locked_hide: assert property (p_locked_hide)
		else $error("security register visible while locked");
endmodule

// file: tb/flash_array_model.sv
// behavioural flash array with an application bank and a loader bank
// assumes commands from isp_flash_seq held until the cycle after done
`timescale 1ns/1ps
module flash_array_model #(
	parameter int LAT = 3
) (
	input  wire logic                      mclk_i,
	input  isp_flash_pkg::flash_cmd_s      cmd_i,
	output logic                           done_o,
	output logic [7:0]                     rdata_o
);
	logic [7:0]                mem [2][256];
	int                        cnt;
	isp_flash_pkg::flash_cmd_s last;

	initial begin
		foreach (mem[b, a]) mem[b][a] = 8'hff;
		cnt = 0;
		done_o = 1'b0;
		rdata_o = 8'h00;
	end

	// read data toggles outside the done cycle
	always @(posedge mclk_i) begin
		if (done_o) begin
			done_o <= 1'b0;
			rdata_o <= ~rdata_o;
		end else if (cmd_i.req && cnt < LAT) begin
			cnt <= cnt + 1;
			rdata_o <= ~rdata_o;
		end else if (cmd_i.req) begin
			cnt <= 0;
			done_o <= 1'b1;
			last <= cmd_i;
			case (cmd_i.op)
			isp_flash_pkg::OP_ERASE: begin
				for (int a = 0; a < 256; a++) mem[cmd_i.bank][a] <= 8'hff;
			end
			isp_flash_pkg::OP_PROG: begin
				mem[cmd_i.bank][cmd_i.addr[7:0]] <= cmd_i.wdata;
			end
			default: begin
				rdata_o <= mem[cmd_i.bank][cmd_i.addr[7:0]];
			end
			endcase
		end
	end
endmodule

// file: tb/isp_flash_command_and_security_tb_top.sv
// self-checking bench for isp_flash_seq over apb
// assumes zero-wait apb answers and the flash array model on the far side
`timescale 1ns/1ps
module isp_flash_command_and_security_tb_top;
	logic                      mclk_i = 1'b0;
	logic                      resetn_i = 1'b0;
	logic [7:0]                paddr = 8'h00;
	logic                      psel = 1'b0;
	logic                      penable = 1'b0;
	logic                      pwrite = 1'b0;
	logic [31:0]               pwdata = 32'h0;
	logic [31:0]               prdata_o;
	logic                      pready_o;
	logic                      pslverr_o;
	logic                      prog_mode = 1'b0;
	logic [7:0]                sec_bits = 8'hff;
	logic                      full_erase = 1'b0;
	logic                      done;
	logic [7:0]                rdata;
	isp_flash_pkg::flash_cmd_s cmd;
	logic                      from_int = 1'b0;
	logic                      to_int = 1'b0;
	logic                      ok_o;
	logic                      cyc6_o;
	logic                      x40_o;
	int                        fails = 0;
	int                        num_checks = 0;

	initial begin
		forever #2 mclk_i = ~mclk_i;
	end

	isp_flash_seq isp_flash_seq_inst (
		.mclk_i(mclk_i), .resetn_i(resetn_i), .paddr_i(paddr),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .prog_mode_i(prog_mode),
		.sec_bits_i(sec_bits), .full_erase_i(full_erase),
		.flash_done_i(done), .flash_rdata_i(rdata), .flash_cmd_o(cmd),
		.movc_from_int_i(from_int), .movc_to_int_i(to_int),
		.movc_int_ok_o(ok_o), .cycle_6t_o(cyc6_o), .xtal_40m_o(x40_o)
	);

	flash_array_model flash_array_model_inst (
		.mclk_i(mclk_i), .cmd_i(cmd), .done_o(done), .rdata_o(rdata)
	);

	task automatic give_verdict;
		if (fails == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] rd, output logic err);
		int n;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		penable <= 1'b0;
		@(posedge mclk_i);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			fails++;
			$display("wrong value at %0t: no bus answer", $time);
		end
		rd = prdata_o;
		err = pslverr_o;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] rd;
		logic        err;
		apb(a, 1'b1, {24'h0, d}, rd, err);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		logic        err;
		apb(a, 1'b0, 32'h0, rd, err);
		chk(rd, exp);
	endtask

	// start an operation and poll the busy flag under a bound
	task automatic go(input logic [7:0] ctrl);
		logic [31:0] rd;
		logic        err;
		int          n;
		wr(isp_flash_pkg::OFS_CTRL, ctrl);
		wr(isp_flash_pkg::OFS_GO, 8'h00);
		n = 0;
		do begin
			apb(isp_flash_pkg::OFS_STAT, 1'b0, 32'h0, rd, err);
			n++;
		end while (rd[isp_flash_pkg::STAT_BUSY] !== 1'b0 && n < 20);
		if (n >= 20) begin
			fails++;
			$display("wrong value at %0t: operation never ended", $time);
		end
	endtask

	task automatic do_reset(input logic [7:0] s);
		sec_bits <= s;
		resetn_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		resetn_i <= 1'b1;
		repeat (4) @(posedge mclk_i);
	endtask

	task automatic movc_sweep(input logic b1);
		for (int i = 0; i < 4; i++) begin
			from_int <= i[0];
			to_int <= i[1];
			repeat (2) @(posedge mclk_i);
			chk(ok_o, {31'h0, (i[0] | ~i[1] | b1)});
		end
	endtask

	initial begin
		logic [31:0] rd;
		logic        err;
		do_reset(8'hff);
		chk(cyc6_o, 0);
		chk(x40_o, 1);
		rdchk(isp_flash_pkg::OFS_SEC, 32'hff);
		rdchk(isp_flash_pkg::OFS_MID, 32'h5a);
		wr(isp_flash_pkg::OFS_MID, 8'ha5);
		rdchk(isp_flash_pkg::OFS_MID, 32'h5a);
		rdchk(isp_flash_pkg::OFS_DID, 32'h3c);
		apb(8'h30, 1'b0, 32'h0, rd, err);
		chk(err, 1);
		wr(isp_flash_pkg::OFS_CTRL, 8'h21);
		rdchk(isp_flash_pkg::OFS_CTRL, 32'h0);
		wr(isp_flash_pkg::OFS_KEY, isp_flash_pkg::KEY_FIRST);
		wr(isp_flash_pkg::OFS_KEY, isp_flash_pkg::KEY_SECOND);
		rdchk(isp_flash_pkg::OFS_STAT, 32'h1);
		wr(isp_flash_pkg::OFS_AH, 8'h12);
		wr(isp_flash_pkg::OFS_AL, 8'h34);
		wr(isp_flash_pkg::OFS_DATA, 8'ha5);
		go(8'h21);
		chk(flash_array_model_inst.last.addr, 16'h1234);
		wr(isp_flash_pkg::OFS_DATA, 8'h5a);
		go(8'h61);
		go(8'h00);
		rdchk(isp_flash_pkg::OFS_DATA, 32'ha5);
		go(8'h40);
		rdchk(isp_flash_pkg::OFS_DATA, 32'h5a);
		go(8'h22);
		go(8'h00);
		rdchk(isp_flash_pkg::OFS_DATA, 32'hff);
		go(8'h40);
		rdchk(isp_flash_pkg::OFS_DATA, 32'h5a);
		go(8'h31);
		rdchk(isp_flash_pkg::OFS_STAT, 32'h11);
		wr(isp_flash_pkg::OFS_KEY, 8'h00);
		wr(isp_flash_pkg::OFS_CTRL, 8'h22);
		rdchk(isp_flash_pkg::OFS_CTRL, 32'h31);
		movc_sweep(1'b1);
		prog_mode <= 1'b1;
		repeat (5) @(posedge mclk_i);
		rdchk(isp_flash_pkg::OFS_SEC, 32'h0);
		rdchk(isp_flash_pkg::OFS_DID, 32'h0);
		prog_mode <= 1'b0;
		repeat (5) @(posedge mclk_i);
		do_reset(8'h5c);
		chk(cyc6_o, 1);
		chk(x40_o, 0);
		rdchk(isp_flash_pkg::OFS_SEC, 32'h0);
		wr(isp_flash_pkg::OFS_KEY, isp_flash_pkg::KEY_FIRST);
		wr(isp_flash_pkg::OFS_KEY, isp_flash_pkg::KEY_SECOND);
		go(8'h00);
		rdchk(isp_flash_pkg::OFS_STAT, 32'h19);
		movc_sweep(1'b0);
		sec_bits <= 8'hff;
		repeat (4) @(posedge mclk_i);
		chk(cyc6_o, 1);
		full_erase <= 1'b1;
		@(posedge mclk_i);
		full_erase <= 1'b0;
		repeat (3) @(posedge mclk_i);
		chk(cyc6_o, 0);
		chk(x40_o, 1);
		rdchk(isp_flash_pkg::OFS_SEC, 32'hff);
		give_verdict();
	end
endmodule
